// *** logic/mld_match.sv ***
// MLD snoop qualifier: next-header match per criteria option
`timescale 1ns/1ps
module mld_match (
  input wire logic opt_ext,
  input wire logic [7:0] next_hdr,
  input wire logic [7:0] hbh_next_hdr,
  output logic hit
);
  // One next-header value against the selected criteria set
  function automatic logic nh_ok(input logic ext, input logic [7:0] nh);
    if (ext) begin
      nh_ok = (nh == qos_snoop_pkg::NH_ROUTING) ||
              (nh == qos_snoop_pkg::NH_FRAGMENT) ||
              (nh == qos_snoop_pkg::NH_ESP) ||
              (nh == qos_snoop_pkg::NH_AH) ||
              (nh == qos_snoop_pkg::NH_DEST_OPT);
    end else begin
      nh_ok = (nh == qos_snoop_pkg::NH_ICMP) ||
              (nh == qos_snoop_pkg::NH_ICMPV6);
    end
  endfunction

  // Direct header, or hop-by-hop header followed by a match
  always_comb begin
    hit = nh_ok(opt_ext, next_hdr) ||
          ((next_hdr == qos_snoop_pkg::NH_HOP_BY_HOP) &&
           nh_ok(opt_ext, hbh_next_hdr));
  end
endmodule

// *** logic/qos_snoop_pkg.sv ***
// Package: register map, field layout and reset values of the QoS/snoop bank
package qos_snoop_pkg;
  // Printed offsets are not all multiples of four: indices, byte addr = 4*idx
  localparam logic [11:0] IDX_DSCP_3A_3B = 12'h35d;
  localparam logic [11:0] IDX_DSCP_3C_3D = 12'h35e;
  localparam logic [11:0] IDX_DSCP_3E_3F = 12'h35f;
  localparam logic [11:0] IDX_MIRROR_SNOOP = 12'h370;
  localparam logic [11:0] IDX_WRED_COLOUR = 12'h378;
  localparam logic [11:0] IDX_PTP_EVENT = 12'h37c;
  localparam logic [11:0] IDX_PTP_NONEVENT = 12'h37d;
  // Writable-bit masks; the rest reads zero
  localparam logic [7:0] MASK_DSCP = 8'h77;
  localparam logic [7:0] MASK_MIRROR_SNOOP = 8'h4d;
  localparam logic [7:0] MASK_WRED = 8'h3f;
  localparam logic [7:0] MASK_PTP = 8'h8f;
  // Field positions
  localparam int DSCP_EVEN_LSB = 0;
  localparam int DSCP_ODD_LSB = 4;
  localparam int BIT_IGMP_EN = 6;
  localparam int BIT_MLD_OPT = 3;
  localparam int BIT_MLD_EN = 2;
  localparam int BIT_SNIFF_AND = 0;
  localparam int WRED_RED_LSB = 4;
  localparam int WRED_YELLOW_LSB = 2;
  localparam int WRED_GREEN_LSB = 0;
  localparam int BIT_PTP_OVR = 7;
  // Reset values
  localparam logic [7:0] RST_DSCP = 8'h00;
  localparam logic [7:0] RST_MIRROR_SNOOP = 8'h00;
  localparam logic [7:0] RST_WRED = 8'h39;
  localparam logic [7:0] RST_PTP = 8'h0f;
  // Code points served by the upper map bytes
  localparam logic [5:0] DSCP_FIRST = 6'h3a;
  // IPv6 next-header values
  localparam logic [7:0] NH_HOP_BY_HOP = 8'h00;
  localparam logic [7:0] NH_ICMP = 8'h01;
  localparam logic [7:0] NH_ICMPV6 = 8'h3a;
  localparam logic [7:0] NH_ROUTING = 8'h2b;
  localparam logic [7:0] NH_FRAGMENT = 8'h2c;
  localparam logic [7:0] NH_ESP = 8'h32;
  localparam logic [7:0] NH_AH = 8'h33;
  localparam logic [7:0] NH_DEST_OPT = 8'h3c;
endpackage

// *** logic/switch_qos_snoop_ctrl.sv ***
// Global QoS / snoop / sniff / PTP priority control bank on APB
// What this block does
// - Map byte holds even/odd 3-bit priorities
// - Code points 3C/3D use map byte 35E
// - Code points 3E/3F use map byte 35F
// - IGMP snoop enable sends IGMP to host
// - MLD snoop enable sends MLD to host
// - Option set: extension headers qualify MLD
// - Option clear: ICMP/ICMPv6 headers qualify MLD
// - Sniff AND mode needs both ports match
// - Sniff OR mode needs either port match
// - WRED colour codes reset 11,10,01
// - Event override forces PTP event priority
// - Non-event override forces PTP non-event priority
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module switch_qos_snoop_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Classifier request: DSCP, IGMP/MLD, sniff and PTP fields of one frame
  input wire logic cls_valid,
  input wire logic [5:0] cls_dscp,
  input wire logic cls_is_ip,
  input wire logic cls_is_igmp,
  input wire logic cls_is_ipv6,
  input wire logic [7:0] cls_next_hdr,
  input wire logic [7:0] cls_hbh_next_hdr,
  input wire logic cls_src_sniff,
  input wire logic cls_dst_sniff,
  input wire logic cls_ptp_event,
  input wire logic cls_ptp_nonevent,
  input wire logic [3:0] cls_qos_prio,
  // Classifier answers, one cycle after cls_valid
  output logic res_valid,
  output logic res_dscp_hit,
  output logic [2:0] res_dscp_prio,
  output logic res_to_host,
  output logic res_sniff,
  output logic [3:0] res_queue_prio,
  // Static configuration levels
  output logic [1:0] wred_red_code,
  output logic [1:0] wred_yellow_code,
  output logic [1:0] wred_green_code
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] map_3a_q; // Code points 3A/3B
  logic [7:0] map_3c_q; // Code points 3C/3D
  logic [7:0] map_3e_q; // Code points 3E/3F
  logic [7:0] snoop_q; // Mirror/snoop globals
  logic [7:0] wred_q; // WRED colour codes
  logic [7:0] ptp_ev_q; // PTP event priority
  logic [7:0] ptp_ne_q; // PTP non-event priority
  logic mld_hit; // MLD criteria match

  // Access phase; one-cycle answer, pready tied from a flop
  logic acc;
  logic wr;
  logic [11:0] idx; // Register index = byte address / 4
  logic mapped;
  assign acc = psel && penable;
  assign wr = acc && pwrite && pstrb[0];
  assign idx = paddr[13:2];

  // Index decode, used for write, read and error check
  function automatic logic is_mapped(input logic [11:0] i);
    case (i)
      qos_snoop_pkg::IDX_DSCP_3A_3B,
      qos_snoop_pkg::IDX_DSCP_3C_3D,
      qos_snoop_pkg::IDX_DSCP_3E_3F,
      qos_snoop_pkg::IDX_MIRROR_SNOOP,
      qos_snoop_pkg::IDX_WRED_COLOUR,
      qos_snoop_pkg::IDX_PTP_EVENT,
      qos_snoop_pkg::IDX_PTP_NONEVENT: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  assign mapped = is_mapped(idx) && (paddr[15:14] == 2'b00) &&
                  (paddr[1:0] == 2'b00);

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; only writable bits stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map_3a_q <= qos_snoop_pkg::RST_DSCP;
      map_3c_q <= qos_snoop_pkg::RST_DSCP;
      map_3e_q <= qos_snoop_pkg::RST_DSCP;
      snoop_q <= qos_snoop_pkg::RST_MIRROR_SNOOP;
      wred_q <= qos_snoop_pkg::RST_WRED;
      ptp_ev_q <= qos_snoop_pkg::RST_PTP;
      ptp_ne_q <= qos_snoop_pkg::RST_PTP;
    end else if (wr && mapped && pready) begin
      // Writes land on the pready edge only
      case (idx)
        qos_snoop_pkg::IDX_DSCP_3A_3B:
          map_3a_q <= pwdata[7:0] & qos_snoop_pkg::MASK_DSCP;
        qos_snoop_pkg::IDX_DSCP_3C_3D:
          map_3c_q <= pwdata[7:0] & qos_snoop_pkg::MASK_DSCP;
        qos_snoop_pkg::IDX_DSCP_3E_3F:
          map_3e_q <= pwdata[7:0] & qos_snoop_pkg::MASK_DSCP;
        qos_snoop_pkg::IDX_MIRROR_SNOOP:
          snoop_q <= pwdata[7:0] & qos_snoop_pkg::MASK_MIRROR_SNOOP;
        qos_snoop_pkg::IDX_WRED_COLOUR:
          wred_q <= pwdata[7:0] & qos_snoop_pkg::MASK_WRED;
        qos_snoop_pkg::IDX_PTP_EVENT:
          ptp_ev_q <= pwdata[7:0] & qos_snoop_pkg::MASK_PTP;
        qos_snoop_pkg::IDX_PTP_NONEVENT:
          ptp_ne_q <= pwdata[7:0] & qos_snoop_pkg::MASK_PTP;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: pready one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      // Pulse: rises after the first access cycle, drops after the handshake
      pready <= acc && !pready;
      pslverr <= acc && !pready && !mapped;
      prdata <= 32'h0000_0000;
      if (acc && !pready && !pwrite && mapped) begin
        // Storage already masked, so reserved bits read zero
        case (idx)
          qos_snoop_pkg::IDX_DSCP_3A_3B: prdata[7:0] <= map_3a_q;
          qos_snoop_pkg::IDX_DSCP_3C_3D: prdata[7:0] <= map_3c_q;
          qos_snoop_pkg::IDX_DSCP_3E_3F: prdata[7:0] <= map_3e_q;
          qos_snoop_pkg::IDX_MIRROR_SNOOP: prdata[7:0] <= snoop_q;
          qos_snoop_pkg::IDX_WRED_COLOUR: prdata[7:0] <= wred_q;
          qos_snoop_pkg::IDX_PTP_EVENT: prdata[7:0] <= ptp_ev_q;
          qos_snoop_pkg::IDX_PTP_NONEVENT: prdata[7:0] <= ptp_ne_q;
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Classification helpers
  // Pick the 3-bit field for a code point; odd uses the upper field
  function automatic logic [2:0] pick(input logic [7:0] b, input logic odd);
    if (odd) begin
      pick = b[qos_snoop_pkg::DSCP_ODD_LSB +: 3];
    end else begin
      pick = b[qos_snoop_pkg::DSCP_EVEN_LSB +: 3];
    end
  endfunction

  logic dscp_hit;
  logic [2:0] dscp_prio;
  // Byte select from code point; lower map bytes live elsewhere
  always_comb begin
    dscp_hit = cls_is_ip && (cls_dscp >= qos_snoop_pkg::DSCP_FIRST);
    case (cls_dscp[2:1])
      2'b01: dscp_prio = pick(map_3a_q, cls_dscp[0]);
      2'b10: dscp_prio = pick(map_3c_q, cls_dscp[0]);
      2'b11: dscp_prio = pick(map_3e_q, cls_dscp[0]);
      default: dscp_prio = 3'h0;
    endcase
  end

  mld_match i_mld_match (
    .opt_ext(snoop_q[qos_snoop_pkg::BIT_MLD_OPT]),
    .next_hdr(cls_next_hdr),
    .hbh_next_hdr(cls_hbh_next_hdr),
    .hit(mld_hit)
  );

  logic igmp_fwd;
  logic mld_fwd;
  logic sniff_d;
  logic [3:0] qprio_d;
  always_comb begin
    igmp_fwd = snoop_q[qos_snoop_pkg::BIT_IGMP_EN] && cls_is_igmp;
    mld_fwd = snoop_q[qos_snoop_pkg::BIT_MLD_EN] && cls_is_ipv6 &&
              mld_hit;
    if (snoop_q[qos_snoop_pkg::BIT_SNIFF_AND]) begin
      sniff_d = cls_src_sniff && cls_dst_sniff;
    end else begin
      sniff_d = cls_src_sniff || cls_dst_sniff;
    end
    // Event wins if a frame is flagged both ways and the event override is set; should not happen
    if (cls_ptp_event && ptp_ev_q[qos_snoop_pkg::BIT_PTP_OVR]) begin
      qprio_d = ptp_ev_q[3:0];
    end else if (cls_ptp_nonevent &&
                 ptp_ne_q[qos_snoop_pkg::BIT_PTP_OVR]) begin
      qprio_d = ptp_ne_q[3:0];
    end else begin
      qprio_d = cls_qos_prio;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered classifier answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_valid <= 1'b0;
      res_dscp_hit <= 1'b0;
      res_dscp_prio <= 3'h0;
      res_to_host <= 1'b0;
      res_sniff <= 1'b0;
      res_queue_prio <= 4'h0;
    end else begin
      res_valid <= cls_valid;
      res_dscp_hit <= cls_valid && dscp_hit;
      res_dscp_prio <= dscp_hit ? dscp_prio : 3'h0;
      res_to_host <= cls_valid && (igmp_fwd || mld_fwd);
      res_sniff <= cls_valid && sniff_d;
      res_queue_prio <= qprio_d;
    end
  end

  // WRED codes out as registered levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wred_red_code <= qos_snoop_pkg::RST_WRED[5:4];
      wred_yellow_code <= qos_snoop_pkg::RST_WRED[3:2];
      wred_green_code <= qos_snoop_pkg::RST_WRED[1:0];
    end else begin
      wred_red_code <= wred_q[qos_snoop_pkg::WRED_RED_LSB +: 2];
      wred_yellow_code <= wred_q[qos_snoop_pkg::WRED_YELLOW_LSB +: 2];
      wred_green_code <= wred_q[qos_snoop_pkg::WRED_GREEN_LSB +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_DSCP_3C: assert property (cls_valid && cls_is_ip &&
    cls_dscp == 6'h3c |=> res_dscp_hit &&
    res_dscp_prio == $past(map_3c_q[2:0]))
    else $error("3C priority wrong");
  AST_DSCP_3F: assert property (cls_valid && cls_is_ip &&
    cls_dscp == 6'h3f |=> res_dscp_prio == $past(map_3e_q[6:4]))
    else $error("3F priority wrong");
  AST_DSCP_3B: assert property (cls_valid && cls_is_ip &&
    cls_dscp == 6'h3b |=> res_dscp_prio == $past(map_3a_q[6:4]))
    else $error("3B priority wrong");
  AST_IGMP: assert property (cls_valid && cls_is_igmp &&
    snoop_q[6] |=> res_to_host) else $error("IGMP not to host");
  AST_MLD_OFF: assert property (cls_valid && !cls_is_igmp &&
    !snoop_q[2] |=> !res_to_host) else $error("MLD snoop while off");
  AST_MLD_EXT: assert property (cls_valid && cls_is_ipv6 &&
    snoop_q[2] && snoop_q[3] && cls_next_hdr == 8'd44 |=> res_to_host)
    else $error("MLD ext criteria miss");
  AST_MLD_ICMP: assert property (cls_valid && cls_is_ipv6 &&
    snoop_q[2] && !snoop_q[3] && cls_next_hdr == 8'd0 &&
    cls_hbh_next_hdr == 8'd58 |=> res_to_host)
    else $error("MLD hop-by-hop miss");
  AST_SNIFF_AND: assert property (cls_valid && snoop_q[0] &&
    cls_src_sniff != cls_dst_sniff |=> !res_sniff)
    else $error("AND sniff on one match");
  AST_SNIFF_OR: assert property (cls_valid && !snoop_q[0] &&
    cls_src_sniff |=> res_sniff) else $error("OR sniff missed");
  AST_WRED_RST: assert property ($rose(presetn) |->
    wred_red_code == 2'b11 && wred_yellow_code == 2'b10 &&
    wred_green_code == 2'b01) else $error("WRED reset wrong");
  AST_PTP_EV: assert property (cls_ptp_event && ptp_ev_q[7] |=>
    res_queue_prio == $past(ptp_ev_q[3:0])) else $error("PTP event prio");
  AST_PTP_NE: assert property (!cls_ptp_event && cls_ptp_nonevent &&
    ptp_ne_q[7] |=> res_queue_prio == $past(ptp_ne_q[3:0]))
    else $error("PTP non-event prio");
  // Bit 7 is the override flag in the PTP pair, reserved everywhere else
  AST_RSVD: assert property (pready && !pwrite && !pslverr |->
    prdata[31:8] == 24'h0 && (!prdata[7] ||
    idx == qos_snoop_pkg::IDX_PTP_EVENT ||
    idx == qos_snoop_pkg::IDX_PTP_NONEVENT))
    else $error("Reserved bits set");
  AST_READY: assert property (acc && !pready |=> pready)
    else $error("No answer");

  COV_WRITE: cover property (wr && mapped && pready);
  COV_SNOOP: cover property (res_to_host);
  COV_PTP: cover property (cls_ptp_event && ptp_ev_q[7]);
  COV_ERR: cover property (pslverr);
endmodule

// *** tb/switch_qos_snoop_ctrl_bench.sv ***
// Self-checking bench for the QoS / snoop control bank
`timescale 1ns/1ps
module switch_qos_snoop_ctrl_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0; // Async reset, active low
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic last_err; // Error flag of the last APB transfer
  logic cls_valid = 1'b0;
  logic [5:0] cls_dscp = 6'h00;
  logic cls_is_ip = 1'b0;
  logic cls_is_igmp = 1'b0;
  logic cls_is_ipv6 = 1'b0;
  logic [7:0] cls_next_hdr = 8'h00;
  logic [7:0] cls_hbh_next_hdr = 8'h00;
  logic cls_src_sniff = 1'b0;
  logic cls_dst_sniff = 1'b0;
  logic cls_ptp_event = 1'b0;
  logic cls_ptp_nonevent = 1'b0;
  logic [3:0] cls_qos_prio = 4'h0;
  logic res_valid, res_dscp_hit, res_to_host, res_sniff;
  logic [2:0] res_dscp_prio;
  logic [3:0] res_queue_prio;
  logic [1:0] wred_red_code, wred_yellow_code, wred_green_code;
  int error_cnt = 0;
  int n_checks = 0;
  // Register table: index, reset value, writable mask
  logic [11:0] idx_tab [7] = '{12'h35d, 12'h35e, 12'h35f, 12'h370,
                                12'h378, 12'h37c, 12'h37d};
  logic [7:0] rst_tab [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h39, 8'h0f, 8'h0f};
  logic [7:0] msk_tab [7] = '{8'h77, 8'h77, 8'h77, 8'h4d, 8'h3f, 8'h8f, 8'h8f};
  // Next-header values: both criteria sets plus misses
  logic [7:0] nh_tab [9] = '{8'h01, 8'h3a, 8'h2b, 8'h2c, 8'h32, 8'h33,
                              8'h3c, 8'h11, 8'h00};

  switch_qos_snoop_ctrl i_switch_qos_snoop_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cls_valid(cls_valid), .cls_dscp(cls_dscp), .cls_is_ip(cls_is_ip),
    .cls_is_igmp(cls_is_igmp), .cls_is_ipv6(cls_is_ipv6),
    .cls_next_hdr(cls_next_hdr), .cls_hbh_next_hdr(cls_hbh_next_hdr),
    .cls_src_sniff(cls_src_sniff), .cls_dst_sniff(cls_dst_sniff),
    .cls_ptp_event(cls_ptp_event), .cls_ptp_nonevent(cls_ptp_nonevent),
    .cls_qos_prio(cls_qos_prio), .res_valid(res_valid),
    .res_dscp_hit(res_dscp_hit), .res_dscp_prio(res_dscp_prio),
    .res_to_host(res_to_host), .res_sniff(res_sniff),
    .res_queue_prio(res_queue_prio), .wred_red_code(wred_red_code),
    .wred_yellow_code(wred_yellow_code), .wred_green_code(wred_green_code));

  // 40 MHz clock
  initial begin
    forever #12.5 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare, count, report at once
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task stop_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One APB transfer; answer taken at the rising edge that sees pready
  task automatic apb(input logic w, input logic [11:0] idx,
                     input logic [31:0] d, input logic [3:0] s,
                     input logic [31:0] exp);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00}; // Byte address is four times the index
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Values read here are those sampled at the edge, before its updates
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n <= 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      stop_test();
    end
    last_err = pslverr;
    if (!w) begin
      chk(prdata, exp);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One classifier request; answer is read in its single valid cycle
  task automatic cls_go(input logic [5:0] dscp, input logic [2:0] kind,
                        input logic [7:0] nh, input logic [7:0] hbh,
                        input logic [1:0] sd, input logic [1:0] ptp,
                        input logic [3:0] qos);
    @(posedge pclk);
    cls_valid <= 1'b1;
    cls_dscp <= dscp;
    {cls_is_ip, cls_is_igmp, cls_is_ipv6} <= kind;
    cls_next_hdr <= nh;
    cls_hbh_next_hdr <= hbh;
    {cls_src_sniff, cls_dst_sniff} <= sd;
    {cls_ptp_event, cls_ptp_nonevent} <= ptp;
    cls_qos_prio <= qos;
    @(posedge pclk);
    cls_valid <= 1'b0;
    @(negedge pclk);
    chk(res_valid, 1);
  endtask

  // Independent model of the MLD header criteria
  function automatic logic mld_ok(input logic opt, input logic [7:0] v);
    if (opt) begin
      return v == 8'd43 || v == 8'd44 || v == 8'd50 || v == 8'd51 ||
             v == 8'd60;
    end
    return v == 8'd1 || v == 8'd58;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic e;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, then reserved bits read zero after all-ones writes
    for (int i = 0; i < 7; i++) begin
      apb(0, idx_tab[i], 0, 4'hf, rst_tab[i]);
    end
    chk({wred_red_code, wred_yellow_code, wred_green_code}, 6'h39);
    for (int i = 0; i < 7; i++) begin
      apb(1, idx_tab[i], 32'hffff_ffff, 4'hf, 0);
      apb(0, idx_tab[i], 0, 4'hf, msk_tab[i]);
    end
    // Write without low strobe is ignored; unmapped index errors
    apb(1, 12'h378, 32'h0000_0000, 4'he, 0);
    apb(0, 12'h378, 0, 4'hf, 8'h3f);
    apb(0, 12'h360, 0, 4'hf, 0);
    chk(last_err, 1);
    // Upper map bytes: priority is code point minus 0x39
    apb(1, 12'h35d, 32'h21, 4'hf, 0);
    apb(1, 12'h35e, 32'h43, 4'hf, 0);
    apb(1, 12'h35f, 32'h65, 4'hf, 0);
    for (int d = 6'h39; d <= 6'h3f; d++) begin
      cls_go(d[5:0], 3'b100, 0, 0, 0, 0, 0);
      chk(res_dscp_hit, d >= 6'h3a);
      chk(res_dscp_prio, d >= 6'h3a ? d - 6'h39 : 0);
    end
    cls_go(6'h3c, 3'b000, 0, 0, 0, 0, 0);
    chk(res_dscp_hit, 0);
    // Snoop enables and both MLD criteria, direct and behind hop-by-hop
    // Bit 0 of c: IGMP enable, bit 1: MLD enable, bit 2: MLD option
    for (int c = 0; c < 8; c++) begin
      apb(1, 12'h370, (c[0] ? 32'h40 : 0) | (c[1] ? 32'h04 : 0) |
          (c[2] ? 32'h08 : 0), 4'hf, 0);
      cls_go(0, 3'b110, 0, 0, 0, 0, 0);
      chk(res_to_host, c[0]);
      for (int j = 0; j < 9; j++) begin
        e = c[1] & mld_ok(c[2], nh_tab[j]);
        cls_go(0, 3'b101, nh_tab[j], 8'h11, 0, 0, 0);
        chk(res_to_host, e);
        cls_go(0, 3'b101, 8'h00, nh_tab[j], 0, 0, 0);
        chk(res_to_host, e);
      end
    end
    // Sniff filter: OR mode then AND mode over all port matches
    for (int c = 0; c < 2; c++) begin
      apb(1, 12'h370, c, 4'hf, 0);
      // Port match flags stand for the per-port mirror settings
      for (int s = 0; s < 4; s++) begin
        cls_go(0, 3'b000, 0, 0, s[1:0], 0, 0);
        chk(res_sniff, c ? &s[1:0] : |s[1:0]);
      end
    end
    // PTP overrides off, then on; event wins when both flags are set
    for (int o = 0; o < 2; o++) begin
      apb(1, 12'h37c, (o ? 32'h80 : 0) | 32'h05, 4'hf, 0);
      apb(1, 12'h37d, (o ? 32'h80 : 0) | 32'h0a, 4'hf, 0);
      for (int p = 0; p < 4; p++) begin
        cls_go(0, 3'b100, 0, 0, 0, p[1:0], 4'h3);
        chk(res_queue_prio, !o ? 3 : p[1] ? 5 : p[0] ? 4'ha : 3);
      end
    end
    // Colour codes reach the ports; a second reset restores them
    apb(1, 12'h378, 32'h1b, 4'hf, 0);
    // Register lands at the ready edge, the port copies one edge later
    repeat (2) @(negedge pclk);
    chk({wred_red_code, wred_yellow_code, wred_green_code}, 6'h1b);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h378, 0, 4'hf, 8'h39);
    apb(0, 12'h37c, 0, 4'hf, 8'h0f);
    stop_test();
  end
endmodule
